// *** sim/serial_codec_model.sv ***
// external serial codec: makes clock and frame sync, sends and captures words
`timescale 1ns/1ns
module serial_codec_model (
   output logic      sclk_in,
   output logic      fs_in,
   output logic      data_a_in,
   output logic      data_b_in,
   input wire logic  data_a_out,
   input wire logic  data_b_out
);
   logic [31:0] cap_a;
   logic [31:0] cap_b;
   initial begin
      sclk_in = 1'b0;
      fs_in = 1'b0;
      data_a_in = 1'b0;
      data_b_in = 1'b0;
      cap_a = 32'h0000_0000;
      cap_b = 32'h0000_0000;
   end
   // one framed word, msb first; clock stands still outside the frame
   task automatic frame(input logic [31:0] wa, input logic [31:0] wb, input int nb);
      int k;
      // step off the hclk edge so the pin synchronisers never race the model
      #2;
      cap_a = 32'h0000_0000;
      cap_b = 32'h0000_0000;
      fs_in = 1'b1;
      data_a_in = wa[nb-1];
      data_b_in = wb[nb-1];
      #32;
      for (k = 0; k <= nb; k++) begin
         if (k > 0) begin
            cap_a = {cap_a[30:0], data_a_out};
            cap_b = {cap_b[30:0], data_b_out};
         end
         sclk_in = 1'b1;
         if (k > 0 && k < nb) begin
            data_a_in = wa[nb-1-k];
            data_b_in = wb[nb-1-k];
         end
         #32;
         sclk_in = 1'b0;
         fs_in = 1'b0;
         #32;
      end
      // released lines show the inverse so stale bits never look valid
      data_a_in = ~data_a_in;
      data_b_in = ~data_b_in;
   endtask
endmodule

// *** sim/serial_port_buffer_status_chk.sv ***
// port assertions for the serial port buffer and status block
`timescale 1ns/1ns
module serial_port_buffer_status_chk (
   input wire logic                              hclk,
   input wire logic                              hresetn,
   input wire logic                              hsel,
   input wire logic [sport_buf_pkg::ADDR_W-1:0]  haddr,
   input wire logic [1:0]                        htrans,
   input wire logic                              hwrite,
   input wire logic                              hready,
   input wire logic                              hreadyout,
   input wire logic [31:0]                       hrdata,
   input wire logic                              hresp,
   input wire logic                              data_oe,
   input wire logic                              tx_irq
);
   import sport_buf_pkg::*;
   logic       dph;
   logic       rd_q;
   logic [5:0] a_q;
   // data phase tracker, so read data can be tied to the access it answers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph  <= 1'b0;
         rd_q <= 1'b0;
         a_q  <= 6'h00;
      end else if (hsel && htrans[1] && hready) begin
         dph  <= 1'b1;
         rd_q <= !hwrite;
         a_q  <= haddr[7:2];
      end else if (hreadyout) begin
         dph  <= 1'b0;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_take; hsel && htrans[1] && hready; endsequence
   sequence s_ctl_done; dph && hreadyout && rd_q && a_q == 6'h00; endsequence
   property p_wait; s_take |=> !hreadyout; endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_hold; !(dph && hreadyout) |-> $stable(hrdata); endproperty
   property p_stat_a; s_ctl_done |-> hrdata[31:30] != 2'b01; endproperty
   property p_stat_b; s_ctl_done |-> hrdata[28:27] != 2'b01; endproperty
   property p_irq_pulse; tx_irq |=> !tx_irq; endproperty
   property p_irq_oe; tx_irq |-> ##[0:2] data_oe; endproperty
   property p_oe_word; $rose(data_oe) |-> data_oe [*8]; endproperty
   a_wait: assert property (p_wait)
      else $error("no wait state after address phase");
   a_okay: assert property (p_okay)
      else $error("response not okay");
   a_hold: assert property (p_hold)
      else $error("read data moved outside completion");
   a_stat_a: assert property (p_stat_a)
      else $error("channel a status reserved code");
   a_stat_b: assert property (p_stat_b)
      else $error("channel b status reserved code");
   a_irq_pulse: assert property (p_irq_pulse)
      else $error("transmit interrupt longer than one cycle");
   a_irq_oe: assert property (p_irq_oe)
      else $error("interrupt without shifter load");
   a_oe_word: assert property (p_oe_word)
      else $error("word shorter than expected");
endmodule

// *** sim/serial_port_buffer_status_tb_top.sv ***
// testbench for the serial port buffer and status block
`timescale 1ns/1ns
module serial_port_buffer_status_tb_top;
   import sport_buf_pkg::*;
   localparam logic [31:0] RX_CTL = 32'h0000_2071;
   localparam logic [31:0] TX_CTL = 32'h0200_2071;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, hready, hreadyout, hresp, tx_irq;
   logic sclk_in, fs_in, fs_out, fs_oe, data_oe;
   logic data_a_in, data_b_in, data_a_out, data_b_out;
   logic [ADDR_W-1:0] haddr;
   logic [1:0]  htrans, dma_tx_req, dma_tx_wr, dma_rx_req, dma_rx_rd;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rdv, dma_tx_data, rx_head_a, rx_head_b;
   int          failures, num_checks, base;
   int          irq_cnt = 0;
   assign hready = hreadyout;
   serial_port_buffer_status DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .sclk_in(sclk_in), .fs_in(fs_in), .fs_out(fs_out), .fs_oe(fs_oe),
      .data_a_in(data_a_in), .data_b_in(data_b_in), .data_a_out(data_a_out),
      .data_b_out(data_b_out), .data_oe(data_oe), .dma_tx_req(dma_tx_req),
      .dma_tx_wr(dma_tx_wr), .dma_tx_data(dma_tx_data), .dma_rx_req(dma_rx_req),
      .dma_rx_rd(dma_rx_rd), .dma_rx_data_a(rx_head_a), .dma_rx_data_b(rx_head_b),
      .tx_irq(tx_irq));
   serial_codec_model codec (.sclk_in(sclk_in), .fs_in(fs_in), .data_a_in(data_a_in),
      .data_b_in(data_b_in), .data_a_out(data_a_out), .data_b_out(data_b_out));
   always #4 hclk = ~hclk;
   always @(posedge hclk) if (tx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one single ahb transfer; the master waits for ready, bounded by a limit
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
      htrans <= 2'b00;
      hwdata <= wd;
      do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 500);
      rdv = hrdata;
      check("bus ready", {31'h0, n < 500}, 32'h1);
   endtask
   task rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      check(what, rdv, exp);
   endtask
   task stat(input logic [5:0] exp);
      bus(1'b0, OFS_CTL, 32'h0000_0000);
      check("status", {26'h0, rdv[31:26]}, {26'h0, exp});
   endtask
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      close_out;
   end
   initial begin
      hresetn = 0; hsel = 0; hwrite = 0; haddr = 0; htrans = 0;
      hsize = 3'b010; hwdata = 0; dma_tx_wr = 0; dma_tx_data = 0; dma_rx_rd = 0;
      failures = 0; num_checks = 0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rdchk("ctl reset", OFS_CTL, CTL_RESET);
      rdchk("aux reset", OFS_AUX, {30'h0, AUX_RESET});
      rdchk("unmapped", 8'h1C, 32'h0000_0000);
      bus(1'b1, OFS_CTL, RX_CTL);
      stat(6'b000000);
      codec.frame(32'h0000_00A5, 32'h0000_003C, 8);
      stat(6'b100100);
      check("rx a head", rx_head_a, 32'h0000_00A5);
      check("rx b head", rx_head_b, 32'h0000_003C);
      check("rx dma req", {30'h0, dma_rx_req}, 32'h0);
      codec.frame(32'h0000_005A, 32'h0000_00C3, 8);
      stat(6'b110110);
      codec.frame(32'h0000_000F, 32'h0000_00F0, 8);
      stat(6'b111111);
      rdchk("rx a first", OFS_RXA, 32'h0000_00A5);
      rdchk("rx a newest", OFS_RXA, 32'h0000_000F);
      stat(6'b001111);
      bus(1'b1, OFS_CTL, RX_CTL & 32'hFFFF_FFFE);
      stat(6'b000110);
      bus(1'b1, OFS_CTL, TX_CTL);
      stat(6'b000000);
      bus(1'b1, OFS_TXA, 32'h0000_0096);
      bus(1'b1, OFS_TXB, 32'h0000_0069);
      stat(6'b100100);
      base = irq_cnt;
      // second word stalls on the full hold register until the shifter takes the first
      fork
         bus(1'b1, OFS_TXA, 32'h0000_0055);
         codec.frame(32'h0, 32'h0, 8);
      join
      check("tx a word", codec.cap_a, 32'h0000_0096);
      check("tx b word", codec.cap_b, 32'h0000_0069);
      check("irq on load", {31'h0, irq_cnt != base}, 32'h1);
      stat(6'b100000);
      codec.frame(32'h0, 32'h0, 8);
      check("tx a queued", codec.cap_a, 32'h0000_0055);
      check("tx b resent", codec.cap_b, 32'h0000_0069);
      stat(6'b000001);
      bus(1'b1, OFS_MASK, 32'h0000_0001);
      bus(1'b1, OFS_TXA, 32'h0000_0033);
      base = irq_cnt;
      codec.frame(32'h0, 32'h0, 8);
      check("irq masked", {31'h0, irq_cnt != base}, 32'h0);
      check("tx a masked word", codec.cap_a, 32'h0000_0033);
      // dma fills channel a, no frame sync required: words run back to back
      bus(1'b1, OFS_CTL, TX_CTL & 32'hFFFF_FFFE);
      bus(1'b1, OFS_CTL, 32'h0204_0071);
      stat(6'b000000);
      check("tx dma req", {30'h0, dma_tx_req}, 32'h1);
      dma_tx_data <= 32'h0000_00C3;
      dma_tx_wr   <= 2'b01;
      @(posedge hclk);
      dma_tx_wr   <= 2'b00;
      @(posedge hclk);
      check("tx dma served", {30'h0, dma_tx_req}, 32'h0);
      bus(1'b1, OFS_TXB, 32'h0000_00A6);
      codec.frame(32'h0, 32'h0, 8);
      check("tx a dma word", codec.cap_a, 32'h0000_00C3);
      check("tx b word run", codec.cap_b, 32'h0000_00A6);
      stat(6'b101101);
      // internal sync: data dependent syncs stay quiet while buffers are empty
      bus(1'b1, OFS_CTL, TX_CTL & 32'hFFFF_FFFE);
      bus(1'b1, OFS_CTL, TX_CTL | 32'h0000_4000);
      codec.frame(32'h0, 32'h0, 8);
      stat(6'b000000);
      bus(1'b1, OFS_AUX, 32'h0000_0003);
      codec.frame(32'h0, 32'h0, 8);
      stat(6'b101101);
      check("fs pins", {30'h0, fs_oe, fs_out}, 32'h3);
      close_out;
   end
endmodule
bind serial_port_buffer_status serial_port_buffer_status_chk u_chk (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
   .data_oe(data_oe), .tx_irq(tx_irq));

// *** src/serial_port_buffer_status.sv ***
// serial port data buffers, buffer status, error flags and ahb-lite register slave
//
// Chosen here: the address map and the AHB-Lite slave port.
`timescale 1ns/1ns
module serial_port_buffer_status (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [sport_buf_pkg::ADDR_W-1:0] haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic [31:0]                        hrdata,
   output logic                               hresp,
   input  wire logic                          sclk_in,
   input  wire logic                          fs_in,
   output logic                               fs_out,
   output logic                               fs_oe,
   input  wire logic                          data_a_in,
   input  wire logic                          data_b_in,
   output logic                               data_a_out,
   output logic                               data_b_out,
   output logic                               data_oe,
   output logic [1:0]                         dma_tx_req,
   input  wire logic [1:0]                    dma_tx_wr,
   input  wire logic [31:0]                   dma_tx_data,
   output logic [1:0]                         dma_rx_req,
   input  wire logic [1:0]                    dma_rx_rd,
   output logic [31:0]                        dma_rx_data_a,
   output logic [31:0]                        dma_rx_data_b,
   output logic                               tx_irq
);
   import sport_buf_pkg::*;

   state_t st_reg;
   state_t st_next;

   function automatic logic [1:0] occ_code(input logic any, input logic full);
      occ_code = {any, full & any};
   endfunction

   logic       en;
   logic       tx_dir;
   logic       frame_sync_required;
   logic       ifs;
   logic       bhd;
   logic [4:0] slen;
   logic [1:0] dma_en;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       fs_level;
   logic       int_fs;
   logic       fs_now;
   logic       tx_last;
   logic       tx_start;
   logic [1:0] st_any;
   logic [1:0] st_full;
   logic [31:0] ctl_view;

   always_comb begin
      en        = st_reg.ctl[BIT_EN];
      tx_dir    = st_reg.ctl[BIT_DIR];
      frame_sync_required       = st_reg.ctl[BIT_FSR];
      ifs       = st_reg.ctl[BIT_IFS];
      bhd       = st_reg.ctl[BIT_BHD];
      slen      = st_reg.ctl[BIT_SLEN_L +: 5];
      dma_en    = {st_reg.ctl[BIT_DMA_B], st_reg.ctl[BIT_DMA_A]};
      // edges come from the second and third stages, never the first
      sclk_rise = st_reg.sync2[3] & ~st_reg.sync3[3];
      sclk_fall = ~st_reg.sync2[3] & st_reg.sync3[3];
      fs_level  = st_reg.sync2[2] ^ st_reg.ctl[BIT_LFS];
      tx_last   = st_reg.tx_busy & (st_reg.tx_cnt == 5'd0);
      // in transmit, internal sync waits for new data unless MC and data independent syncs are both on;
      // only offered at a word boundary so the partner never sees a sync mid-word
      int_fs    = tx_dir ? ((~st_reg.tx_busy | tx_last)
                            & ((st_reg.aux[BIT_MC] & st_reg.aux[BIT_DATA_INDEPENDENT_SYNC]) | (|st_reg.tx_full)))
                         : ~st_reg.rx_busy;
      fs_now    = sclk_rise & en & (ifs ? int_fs : fs_level);
      // without frame sync required the port keeps sending word after word
      tx_start  = en & tx_dir & (~st_reg.tx_busy | tx_last) & sclk_rise
                  & (fs_now | (tx_last & ~frame_sync_required));
      for (int c = 0; c < NCH; c++) begin
         if (tx_dir) begin
            st_any[c]  = st_reg.tx_full[c] | st_reg.tx_busy;
            st_full[c] = st_reg.tx_full[c] & st_reg.tx_busy;
         end else begin
            st_any[c]  = st_reg.rx_cnt[c] != 2'd0;
            st_full[c] = st_reg.rx_cnt[c] == 2'd2;
         end
      end
      ctl_view = st_reg.ctl & CTL_WMASK;
      ctl_view[BIT_STAT_A +: 2] = occ_code(st_any[0], st_full[0]);
      ctl_view[BIT_STAT_B +: 2] = occ_code(st_any[1], st_full[1]);
      ctl_view[BIT_ERR_A]       = st_reg.err[0];
      ctl_view[BIT_ERR_B]       = st_reg.err[1];
   end

   logic        ok;
   logic        ch;
   logic [31:0] rd;

   always_comb begin
      st_next       = st_reg;
      st_next.sync1 = {sclk_in, fs_in, data_a_in, data_b_in};
      st_next.sync2 = st_reg.sync1;
      st_next.sync3 = st_reg.sync2;
      st_next.irq   = 1'b0;
      ok            = 1'b0;
      ch            = 1'b0;
      rd            = 32'h0000_0000;

      if (sclk_rise) begin
         st_next.fs_out = ifs & en & int_fs;
      end

      // transmit shifting; output changes on the serial clock rise
      if (en & tx_dir & sclk_rise & st_reg.tx_busy & ~tx_last) begin
         st_next.tx_cnt = st_reg.tx_cnt - 5'd1;
         for (int c = 0; c < NCH; c++) begin
            st_next.dout[c] = st_reg.tx_sh[c][5'(st_reg.tx_cnt - 5'd1)];
         end
      end
      if (en & tx_dir & sclk_rise & tx_last) begin
         st_next.tx_busy = 1'b0;
      end
      if (tx_start) begin
         st_next.tx_busy = 1'b1;
         st_next.tx_cnt  = slen;
         for (int c = 0; c < NCH; c++) begin
            if (st_reg.tx_full[c]) begin
               st_next.tx_sh[c]   = st_reg.tx_hold[c];
               st_next.tx_full[c] = 1'b0;
               st_next.dout[c]    = st_reg.tx_hold[c][slen];
               if (~dma_en[c] & ~st_reg.mask) begin
                  st_next.irq = 1'b1;
               end
            end else begin
               // empty buffer: old shifter contents go out again
               st_next.err[c]  = 1'b1;
               st_next.dout[c] = st_reg.tx_sh[c][slen];
            end
         end
      end

      // receive: sync seen on the rise, bits sampled on the fall
      if (en & ~tx_dir & fs_now & ~st_reg.rx_busy) begin
         st_next.rx_busy = 1'b1;
         st_next.rx_bit  = slen;
         st_next.rx_sh   = '0;
      end
      if (en & ~tx_dir & sclk_fall & st_reg.rx_busy) begin
         for (int c = 0; c < NCH; c++) begin
            // zero fill keeps short words right-justified
            st_next.rx_sh[c] = {st_reg.rx_sh[c][30:0], st_reg.sync2[1-c]};
         end
         if (st_reg.rx_bit == 5'd0) begin
            st_next.rx_busy = 1'b0;
            for (int c = 0; c < NCH; c++) begin
               if (st_reg.rx_cnt[c] == 2'd2) begin
                  st_next.rx_fifo[c][1] = st_next.rx_sh[c];
                  st_next.err[c]        = 1'b1;
               end else begin
                  st_next.rx_fifo[c][st_reg.rx_cnt[c][0]] = st_next.rx_sh[c];
                  st_next.rx_cnt[c] = st_reg.rx_cnt[c] + 2'd1;
               end
            end
         end else begin
            st_next.rx_bit = st_reg.rx_bit - 5'd1;
         end
      end

      // dma side of the buffers
      for (int c = 0; c < NCH; c++) begin
         if (dma_tx_wr[c] & tx_dir) begin
            st_next.tx_hold[c] = dma_tx_data;
            st_next.tx_full[c] = 1'b1;
         end
         if (dma_rx_rd[c] & ~tx_dir & (st_next.rx_cnt[c] != 2'd0)) begin
            st_next.rx_fifo[c][0] = st_next.rx_fifo[c][1];
            st_next.rx_cnt[c]     = st_next.rx_cnt[c] - 2'd1;
         end
      end

      // bus data phase; completes once the access may proceed
      if (st_reg.dp_valid & st_reg.dp_done) begin
         st_next.dp_valid = 1'b0;
         st_next.dp_done  = 1'b0;
      end else if (st_reg.dp_valid) begin
         unique case (st_reg.dp_addr)
            OFS_TXA, OFS_TXB: begin
               ch = st_reg.dp_addr == OFS_TXB;
               // inactive buffer never completes while enabled
               ok = ~en | (tx_dir & (~st_next.tx_full[ch] | bhd | ~st_reg.dp_write));
               if (ok & st_reg.dp_write) begin
                  st_next.tx_hold[ch] = hwdata;
                  st_next.tx_full[ch] = 1'b1;
               end
            end
            OFS_RXA, OFS_RXB: begin
               ch = st_reg.dp_addr == OFS_RXB;
               ok = ~en | (~tx_dir & ((st_next.rx_cnt[ch] != 2'd0) | bhd | st_reg.dp_write));
               rd = st_next.rx_fifo[ch][0];
               if (ok & ~st_reg.dp_write & (st_next.rx_cnt[ch] != 2'd0)) begin
                  st_next.rx_fifo[ch][0] = st_next.rx_fifo[ch][1];
                  st_next.rx_cnt[ch]     = st_next.rx_cnt[ch] - 2'd1;
               end
            end
            OFS_CTL: begin
               ok = 1'b1;
               rd = ctl_view;
               if (st_reg.dp_write) begin
                  st_next.ctl = hwdata & CTL_WMASK;
               end
            end
            OFS_AUX: begin
               ok = 1'b1;
               rd = {30'h0000_0000, st_reg.aux};
               if (st_reg.dp_write) begin
                  st_next.aux = hwdata[1:0];
               end
            end
            OFS_MASK: begin
               ok = 1'b1;
               rd = {31'h0000_0000, st_reg.mask};
               if (st_reg.dp_write) begin
                  st_next.mask = hwdata[0];
               end
            end
            default: begin
               ok = 1'b1;
            end
         endcase
         if (ok) begin
            st_next.dp_done = 1'b1;
            st_next.rdata   = st_reg.dp_write ? 32'h0000_0000 : rd;
         end
      end
      if (hsel & htrans[1] & hready) begin
         st_next.dp_valid = 1'b1;
         st_next.dp_write = hwrite;
         st_next.dp_addr  = {haddr[7:2], 2'b00};
         st_next.dp_done  = 1'b0;
      end

      // disabling aborts shifting and clears the sticky flags
      if (~st_next.ctl[BIT_EN]) begin
         st_next.err     = 2'b00;
         st_next.tx_busy = 1'b0;
         st_next.rx_busy = 1'b0;
         st_next.fs_out  = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg      <= '0;
         st_reg.ctl  <= CTL_RESET;
         st_reg.aux  <= AUX_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   always_comb begin
      hreadyout     = ~st_reg.dp_valid | st_reg.dp_done;
      hrdata        = st_reg.rdata;
      hresp         = 1'b0;
      fs_out        = st_reg.fs_out;
      fs_oe         = en & ifs;
      data_a_out    = st_reg.dout[0];
      data_b_out    = st_reg.dout[1];
      data_oe       = en & tx_dir & st_reg.tx_busy;
      dma_rx_data_a = st_reg.rx_fifo[0][0];
      dma_rx_data_b = st_reg.rx_fifo[1][0];
      tx_irq        = st_reg.irq;
      for (int c = 0; c < NCH; c++) begin
         dma_tx_req[c] = en & tx_dir & dma_en[c] & ~st_reg.tx_full[c];
         dma_rx_req[c] = en & ~tx_dir & dma_en[c] & (st_reg.rx_cnt[c] != 2'd0);
      end
   end
endmodule

// *** src/sport_buf_pkg.sv ***
// constants and types for the serial port buffer and status block
package sport_buf_pkg;
   localparam int WORD_W = 32;
   localparam int ADDR_W = 8;
   localparam int NCH    = 2;

   localparam logic [7:0] OFS_CTL  = 8'h00;
   localparam logic [7:0] OFS_TXA  = 8'h04;
   localparam logic [7:0] OFS_TXB  = 8'h08;
   localparam logic [7:0] OFS_RXA  = 8'h0C;
   localparam logic [7:0] OFS_RXB  = 8'h10;
   localparam logic [7:0] OFS_AUX  = 8'h14;
   localparam logic [7:0] OFS_MASK = 8'h18;

   localparam int BIT_EN     = 0;
   localparam int BIT_SLEN_L = 4;
   localparam int BIT_FSR    = 13;
   localparam int BIT_IFS    = 14;
   localparam int BIT_LFS    = 16;
   localparam int BIT_DMA_A  = 18;
   localparam int BIT_DMA_B  = 20;
   localparam int BIT_BHD    = 23;
   localparam int BIT_DIR    = 25;
   localparam int BIT_ERR_B  = 26;
   localparam int BIT_STAT_B = 27;
   localparam int BIT_ERR_A  = 29;
   localparam int BIT_STAT_A = 30;
   localparam int BIT_MC     = 0;
   localparam int BIT_DATA_INDEPENDENT_SYNC   = 1;

   localparam logic [31:0] CTL_RESET = 32'h0000_0000;
   localparam logic [31:0] CTL_WMASK = 32'h03FF_FFFF;
   localparam logic [1:0]  AUX_RESET = 2'b00;

   typedef struct packed {
      logic [31:0]           ctl;
      logic [1:0]            aux;
      logic                  mask;
      logic [3:0]            sync1;
      logic [3:0]            sync2;
      logic [3:0]            sync3;
      logic [1:0][31:0]      tx_hold;
      logic [1:0]            tx_full;
      logic [1:0][31:0]      tx_sh;
      logic                  tx_busy;
      logic [4:0]            tx_cnt;
      logic [1:0]            dout;
      logic                  fs_out;
      logic [1:0]            err;
      logic [1:0][1:0][31:0] rx_fifo;
      logic [1:0][1:0]       rx_cnt;
      logic [1:0][31:0]      rx_sh;
      logic                  rx_busy;
      logic [4:0]            rx_bit;
      logic                  irq;
      logic                  dp_valid;
      logic                  dp_write;
      logic [7:0]            dp_addr;
      logic                  dp_done;
      logic [31:0]           rdata;
   } state_t;
endpackage
